// [rtl/blk_cfg_pkg.sv]
/*
 * constants of the block-device configuration space: byte offsets,
 * feature bit positions, status and mode bits, cache codes, request codes.
 * assumes a 32-bit classic wishbone bus with byte addresses.
 */
`default_nettype none

package blk_cfg_pkg;

  // ***********************************
  // bus geometry
  // ***********************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ***********************************
  // register byte offsets
  // ***********************************
  localparam logic [7:0] OFF_CAP_LO = 8'h00;
  localparam logic [7:0] OFF_CAP_HI = 8'h04;
  localparam logic [7:0] OFF_SEG_BYTES = 8'h08;
  localparam logic [7:0] OFF_SEG_COUNT = 8'h0C;
  localparam logic [7:0] OFF_GEOMETRY = 8'h10;
  localparam logic [7:0] OFF_BLOCK_BYTES = 8'h14;
  localparam logic [7:0] OFF_TOPO_LO = 8'h18;
  localparam logic [7:0] OFF_TOPO_OPT = 8'h1C;
  localparam logic [7:0] OFF_CACHE = 8'h20;
  localparam logic [7:0] OFF_DISC_SECT = 8'h24;
  localparam logic [7:0] OFF_DISC_SEG = 8'h28;
  localparam logic [7:0] OFF_DISC_ALIGN = 8'h2C;
  localparam logic [7:0] OFF_ZERO_SECT = 8'h30;
  localparam logic [7:0] OFF_ZERO_SEG = 8'h34;
  localparam logic [7:0] OFF_ZERO_UNMAP = 8'h38;
  localparam logic [7:0] OFF_DEV_FEAT = 8'h40;
  localparam logic [7:0] OFF_DRV_FEAT = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  localparam logic [7:0] OFF_MODE = 8'h4C;

  // ***********************************
  // feature bit positions
  // ***********************************
  localparam int FB_BARRIER = 0;
  localparam int FB_SEG_BYTES = 1;
  localparam int FB_SEG_COUNT = 2;
  localparam int FB_GEOMETRY = 4;
  localparam int FB_READ_ONLY = 5;
  localparam int FB_BLOCK_BYTES = 6;
  localparam int FB_SCSI = 7;
  localparam int FB_FLUSH = 9;
  localparam int FB_TOPOLOGY = 10;
  localparam int FB_CACHE_TOGGLE = 11;
  localparam int FB_DISCARD = 13;
  localparam int FB_ZERO_FILL = 14;

  // ***********************************
  // status, mode and reset values
  // ***********************************
  localparam int ST_ACKNOWLEDGE = 0;
  localparam int ST_DRIVER = 1;
  localparam int ST_DRIVER_READY = 2;
  localparam int ST_FEATURES_ACCEPTED = 3;
  localparam int MODE_LEGACY = 0;
  localparam int MODE_GUEST_BE = 1;
  localparam logic [31:0] DRV_FEAT_RESET = 32'h0000_0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic CACHE_WRITETHROUGH = 1'b0;
  localparam logic CACHE_WRITEBACK = 1'b1;
  localparam logic [7:0] REQ_STATUS_OK = 8'h00;
  localparam logic [7:0] IO_ERROR_STATUS = 8'h01;
  localparam int SECTOR_BYTES = 512;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_type;

endpackage

`default_nettype wire

// [rtl/blk_cfg_space.sv]
/*
 * configuration space and feature negotiation of a paravirtual block
 * device, as a classic wishbone slave, plus the write-request gate.
 * assumes one 25 MHz clock, synchronous active-high reset, and a bus
 * master that holds each request until ack.
 */
// Overview of operation
// - offer segment-size bit 1, segment-count bit 2
// - geometry bit 4, read-only bit 5, block-size 6
// - flush bit 9, topology bit 10
// - cache-toggle bit 11 lets driver switch cache
// - discard bit 13 with its two limits
// - zero-fill bit 14 with its two limits
// - legacy only: barrier bit 0, scsi bit 7
// - 64-bit capacity in 512-byte sectors always present
// - discard and zero-fill limits in 512-byte units
// - topology fields hold exponent, offset, io sizes
// - transfer unit stays 512 bytes regardless
// - cache byte 0 writethrough, 1 writeback
// - read-only device fails every write request
// - flush always offered, so with cache-toggle
// - modern toggle without flush forces cache byte 0
// - both padding areas read zero
// - legacy presents multibyte fields in guest order
// - legacy cache byte accessible before driver bits
// - legacy status write keeps cache, one exception
// - legacy driver feature writes never touch cache
// - read-only write ends io error, storage untouched
`timescale 1ns/1ps
`default_nettype none

module blk_cfg_space #(
  parameter logic [63:0] CAPACITY = 64'h0000_0000_0010_0000,
  parameter logic [31:0] SEG_BYTES = 32'h0001_0000,
  parameter logic [31:0] SEG_COUNT = 32'h0000_0080,
  parameter logic [15:0] CYLINDERS = 16'h0400,
  parameter logic [7:0] HEADS = 8'h10,
  parameter logic [7:0] SECTORS_PER_TRACK = 8'h3F,
  parameter logic [31:0] BLOCK_BYTES = 32'h0000_0200,
  parameter logic [7:0] PHYS_LOG2 = 8'h03,
  parameter logic [7:0] ALIGN_BLOCK = 8'h00,
  parameter logic [15:0] MIN_BLOCKS = 16'h0001,
  parameter logic [31:0] OPT_BLOCKS = 32'h0000_0080,
  parameter logic [31:0] DISC_SECTORS = 32'h0000_FFFF,
  parameter logic [31:0] DISC_SEGMENTS = 32'h0000_0001,
  parameter logic [31:0] DISC_ALIGN = 32'h0000_0008,
  parameter logic [31:0] ZERO_SECTORS = 32'h0000_FFFF,
  parameter logic [31:0] ZERO_SEGMENTS = 32'h0000_0001,
  parameter logic [7:0] ZERO_UNMAP = 8'h01,
  parameter logic OFFER_SEG_BYTES = 1'b1,
  parameter logic OFFER_SEG_COUNT = 1'b1,
  parameter logic OFFER_GEOMETRY = 1'b1,
  parameter logic OFFER_READ_ONLY = 1'b0,
  parameter logic OFFER_BLOCK_BYTES = 1'b1,
  parameter logic OFFER_TOPOLOGY = 1'b1,
  parameter logic OFFER_CACHE_TOGGLE = 1'b1,
  parameter logic OFFER_DISCARD = 1'b1,
  parameter logic OFFER_ZERO_FILL = 1'b1,
  parameter logic OFFER_BARRIER = 1'b1,
  parameter logic OFFER_SCSI = 1'b0,
  parameter logic CACHE_MODE_RESET = 1'b1
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic wb_we_i, // write strobe
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  output logic wb_ack_o, // answer, one cycle
  input wire logic req_valid_i, // request arrives, pulse
  input wire logic req_write_i, // request is a write
  output logic req_done_o, // request judged, pulse
  output logic [7:0] req_status_o, // request status code
  output logic store_en_o, // storage may be written, pulse
  output logic cache_writeback_o, // current cache mode
  output logic features_accepted_o // driver closed negotiation
);

  // ***********************************
  // byte order helpers
  // ***********************************

  // reverse the four bytes of a word
  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // reverse the two bytes of a half word
  function automatic logic [15:0] swap16(input logic [15:0] h);
    swap16 = {h[7:0], h[15:8]};
  endfunction

  // ***********************************
  // registers
  // ***********************************
  blk_cfg_pkg::bus_state_type state_q, state_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] drv_feat_q;
  logic [7:0] status_q, status_d;
  logic [1:0] mode_q, mode_d;
  logic cache_q, cache_d;
  logic req_done_q;
  logic [7:0] req_status_q, req_status_d;
  logic store_en_q;

  // ***********************************
  // decode
  // ***********************************
  logic [7:0] word_adr;
  logic bus_req;
  logic wr_fire;
  logic legacy;
  logic guest_be;
  logic feat_ok;
  logic [31:0] dev_feat;
  logic read_only;
  logic drv_feat_wr;
  logic status_wr;
  logic mode_wr;
  logic cache_wr;
  logic cache_wr_ok;
  logic toggle_no_flush;
  logic feat_ok_rise;
  logic legacy_ready_rise;
  logic [31:0] rd_word;

  // low address bits are lanes, so offsets compare on the word
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign bus_req = wb_cyc_i & wb_stb_i;
  // a write lands at the edge where the master sees ack
  assign wr_fire = bus_req & wb_we_i & (state_q == blk_cfg_pkg::BUS_ANSWER);
  assign legacy = mode_q[blk_cfg_pkg::MODE_LEGACY];
  assign guest_be = legacy & mode_q[blk_cfg_pkg::MODE_GUEST_BE];
  assign feat_ok = status_q[blk_cfg_pkg::ST_FEATURES_ACCEPTED];
  assign read_only = dev_feat[blk_cfg_pkg::FB_READ_ONLY];

  // offered features; flush is offered unconditionally so that it is
  // always present wherever cache-toggle is
  assign dev_feat = (32'(OFFER_SEG_BYTES) << blk_cfg_pkg::FB_SEG_BYTES)
    | (32'(OFFER_SEG_COUNT) << blk_cfg_pkg::FB_SEG_COUNT)
    | (32'(OFFER_GEOMETRY) << blk_cfg_pkg::FB_GEOMETRY)
    | (32'(OFFER_READ_ONLY) << blk_cfg_pkg::FB_READ_ONLY)
    | (32'(OFFER_BLOCK_BYTES) << blk_cfg_pkg::FB_BLOCK_BYTES)
    | (32'h0000_0001 << blk_cfg_pkg::FB_FLUSH)
    | (32'(OFFER_TOPOLOGY) << blk_cfg_pkg::FB_TOPOLOGY)
    | (32'(OFFER_CACHE_TOGGLE) << blk_cfg_pkg::FB_CACHE_TOGGLE)
    | (32'(OFFER_DISCARD) << blk_cfg_pkg::FB_DISCARD)
    | (32'(OFFER_ZERO_FILL) << blk_cfg_pkg::FB_ZERO_FILL)
    | (32'(OFFER_BARRIER & legacy) << blk_cfg_pkg::FB_BARRIER)
    | (32'(OFFER_SCSI & legacy) << blk_cfg_pkg::FB_SCSI);

  // write decode per register
  assign drv_feat_wr = wr_fire & (word_adr == blk_cfg_pkg::OFF_DRV_FEAT);
  assign status_wr = wr_fire & (word_adr == blk_cfg_pkg::OFF_STATUS) & wb_sel_i[0];
  assign mode_wr = wr_fire & (word_adr == blk_cfg_pkg::OFF_MODE) & wb_sel_i[0];
  assign cache_wr = wr_fire & (word_adr == blk_cfg_pkg::OFF_CACHE) & wb_sel_i[0];

  // ***********************************
  // cache mode
  // ***********************************

  // legacy drivers may touch the byte at any time; modern ones once
  // cache-toggle has been accepted and negotiation is closed
  assign cache_wr_ok = legacy
    | (feat_ok & drv_feat_q[blk_cfg_pkg::FB_CACHE_TOGGLE]);
  assign toggle_no_flush = drv_feat_q[blk_cfg_pkg::FB_CACHE_TOGGLE] & ~drv_feat_q[blk_cfg_pkg::FB_FLUSH];
  assign feat_ok_rise = status_wr & ~legacy & wb_dat_i[blk_cfg_pkg::ST_FEATURES_ACCEPTED] & ~feat_ok;
  // the only status write that may move the cache in legacy mode
  assign legacy_ready_rise = status_wr & legacy
    & wb_dat_i[blk_cfg_pkg::ST_DRIVER_READY] & ~status_q[blk_cfg_pkg::ST_DRIVER_READY]
    & ~drv_feat_q[blk_cfg_pkg::FB_CACHE_TOGGLE];

  // driver feature writes never appear here, so they cannot move it
  assign cache_d = (cache_wr & cache_wr_ok) ? wb_dat_i[0]
    : (feat_ok_rise & toggle_no_flush) ? blk_cfg_pkg::CACHE_WRITETHROUGH
    : legacy_ready_rise ? drv_feat_q[blk_cfg_pkg::FB_FLUSH]
    : cache_q;

  // cache register; either mode may be the reset mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cache_q <= CACHE_MODE_RESET;
    end else begin
      cache_q <= cache_d;
    end
  end

  // ***********************************
  // driver features, status, mode
  // ***********************************

  // accepted features are masked to what is offered, one lane each
  generate
    for (genvar i = 0; i < 4; i++) begin : g_feat_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          drv_feat_q[8*i +: 8] <= blk_cfg_pkg::DRV_FEAT_RESET[8*i +: 8];
        end else if (drv_feat_wr & wb_sel_i[i] & ~feat_ok) begin
          drv_feat_q[8*i +: 8] <= wb_dat_i[8*i +: 8] & dev_feat[8*i +: 8];
        end
      end
    end
  endgenerate

  assign status_d = status_wr ? wb_dat_i[7:0] : status_q;
  assign mode_d = mode_wr ? wb_dat_i[1:0] : mode_q;

  // status and interface mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= blk_cfg_pkg::STATUS_RESET;
      mode_q <= blk_cfg_pkg::MODE_RESET;
    end else begin
      status_q <= status_d;
      mode_q <= mode_d;
    end
  end

  // ***********************************
  // read path
  // ***********************************

  // field value at a word offset, in the order the guest expects;
  // legacy big-endian guests see each field swapped within itself
  // every live register comes in as an argument: a continuous assignment
  // only wakes on its arguments, so a hidden read would go stale
  function automatic logic [31:0] read_field(input logic [7:0] a, input logic be, input logic wb_bit,
    input logic [7:0] st, input logic [1:0] md, input logic [31:0] drv, input logic [31:0] dev);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      blk_cfg_pkg::OFF_CAP_LO: w = be ? swap32(CAPACITY[63:32]) : CAPACITY[31:0];
      blk_cfg_pkg::OFF_CAP_HI: w = be ? swap32(CAPACITY[31:0]) : CAPACITY[63:32];
      blk_cfg_pkg::OFF_SEG_BYTES: w = be ? swap32(SEG_BYTES) : SEG_BYTES;
      blk_cfg_pkg::OFF_SEG_COUNT: w = be ? swap32(SEG_COUNT) : SEG_COUNT;
      blk_cfg_pkg::OFF_GEOMETRY: w = {SECTORS_PER_TRACK, HEADS, be ? swap16(CYLINDERS) : CYLINDERS};
      blk_cfg_pkg::OFF_BLOCK_BYTES: w = be ? swap32(BLOCK_BYTES) : BLOCK_BYTES;
      blk_cfg_pkg::OFF_TOPO_LO: w = {be ? swap16(MIN_BLOCKS) : MIN_BLOCKS, ALIGN_BLOCK, PHYS_LOG2};
      blk_cfg_pkg::OFF_TOPO_OPT: w = be ? swap32(OPT_BLOCKS) : OPT_BLOCKS;
      blk_cfg_pkg::OFF_CACHE: w = {31'h0000_0000, wb_bit};
      blk_cfg_pkg::OFF_DISC_SECT: w = be ? swap32(DISC_SECTORS) : DISC_SECTORS;
      blk_cfg_pkg::OFF_DISC_SEG: w = be ? swap32(DISC_SEGMENTS) : DISC_SEGMENTS;
      blk_cfg_pkg::OFF_DISC_ALIGN: w = be ? swap32(DISC_ALIGN) : DISC_ALIGN;
      blk_cfg_pkg::OFF_ZERO_SECT: w = be ? swap32(ZERO_SECTORS) : ZERO_SECTORS;
      blk_cfg_pkg::OFF_ZERO_SEG: w = be ? swap32(ZERO_SEGMENTS) : ZERO_SEGMENTS;
      blk_cfg_pkg::OFF_ZERO_UNMAP: w = {24'h00_0000, ZERO_UNMAP};
      blk_cfg_pkg::OFF_DEV_FEAT: w = be ? swap32(dev) : dev;
      blk_cfg_pkg::OFF_DRV_FEAT: w = be ? swap32(drv) : drv;
      blk_cfg_pkg::OFF_STATUS: w = {24'h00_0000, st};
      blk_cfg_pkg::OFF_MODE: w = {30'h0000_0000, md};
      default: w = 32'h0000_0000;
    endcase
    read_field = w;
  endfunction

  // unmapped offsets answer with zero rather than stalling the bus
  assign rd_word = read_field(word_adr, guest_be, cache_q, status_q, mode_q, drv_feat_q, dev_feat);

  // ***********************************
  // wishbone handshake
  // ***********************************

  // ack always one cycle after the strobe; a fixed latency keeps the
  // master simple at the cost of one wait cycle per access
  assign state_d = (state_q == blk_cfg_pkg::BUS_IDLE) ? (bus_req ? blk_cfg_pkg::BUS_ANSWER : blk_cfg_pkg::BUS_IDLE)
    : blk_cfg_pkg::BUS_IDLE;
  assign rdata_d = (bus_req & ~wb_we_i & (state_q == blk_cfg_pkg::BUS_IDLE)) ? rd_word : rdata_q;

  // bus state and captured read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= blk_cfg_pkg::BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        blk_cfg_pkg::BUS_IDLE: state_q <= state_d;
        blk_cfg_pkg::BUS_ANSWER: state_q <= state_d;
        default: state_q <= blk_cfg_pkg::BUS_IDLE;
      endcase
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = (state_q == blk_cfg_pkg::BUS_ANSWER) & bus_req;
  assign wb_dat_o = rdata_q;

  // ***********************************
  // write request gate
  // ***********************************

  // a read-only device refuses every write before storage sees it
  assign req_status_d = (req_write_i & read_only) ? blk_cfg_pkg::IO_ERROR_STATUS
    : blk_cfg_pkg::REQ_STATUS_OK;

  // verdict one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_done_q <= 1'b0;
      req_status_q <= blk_cfg_pkg::REQ_STATUS_OK;
      store_en_q <= 1'b0;
    end else begin
      req_done_q <= req_valid_i;
      if (req_valid_i) begin
        req_status_q <= req_status_d;
      end
      store_en_q <= req_valid_i & req_write_i & ~read_only;
    end
  end

  assign req_done_o = req_done_q;
  assign req_status_o = req_status_q;
  assign store_en_o = store_en_q;
  assign cache_writeback_o = cache_q;
  assign features_accepted_o = feat_ok;

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_ack;
  logic [31:0] wdat_q;
  assign rd_ack = wb_ack_o & ~wb_we_i;

  // held write data for comparing after the write lands
  always_ff @(posedge clk_i) begin
    wdat_q <= wb_dat_i;
  end

  sequence s_ro_write;
    req_valid_i && req_write_i && read_only;
  endsequence

  sequence s_write_failed;
    req_done_o && (req_status_o == blk_cfg_pkg::IO_ERROR_STATUS) && !store_en_o;
  endsequence

  sequence s_bus_start;
    bus_req && (state_q == blk_cfg_pkg::BUS_IDLE);
  endsequence

  a_bus_answer_once: assert property (s_bus_start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after strobe");

  a_ro_write_fails: assert property (s_ro_write |=> s_write_failed)
    else $error("read-only write not failed");

  a_ro_no_store: assert property (read_only |-> !store_en_o)
    else $error("read-only device enabled storage");

  a_flush_read_back: assert property (rd_ack && word_adr == blk_cfg_pkg::OFF_DEV_FEAT && !guest_be
    |-> wb_dat_o[blk_cfg_pkg::FB_FLUSH])
    else $error("flush not offered");

  a_legacy_bits_hidden: assert property (rd_ack && word_adr == blk_cfg_pkg::OFF_DEV_FEAT && !legacy
    |-> !wb_dat_o[blk_cfg_pkg::FB_BARRIER] && !wb_dat_o[blk_cfg_pkg::FB_SCSI])
    else $error("legacy feature bits offered outside legacy");

  a_capacity_low: assert property (rd_ack && word_adr == blk_cfg_pkg::OFF_CAP_LO && !guest_be
    |-> wb_dat_o == CAPACITY[31:0])
    else $error("capacity low word wrong");

  a_capacity_swapped: assert property (rd_ack && word_adr == blk_cfg_pkg::OFF_CAP_LO && guest_be
    |-> wb_dat_o == swap32(CAPACITY[63:32]))
    else $error("capacity not in guest order");

  a_pad_reads_zero: assert property (rd_ack && word_adr == blk_cfg_pkg::OFF_CACHE
    |-> wb_dat_o[31:1] == 31'h0000_0000)
    else $error("cache padding not zero");

  a_toggle_forces_wt: assert property (feat_ok_rise && toggle_no_flush
    |=> cache_writeback_o == blk_cfg_pkg::CACHE_WRITETHROUGH)
    else $error("cache not writethrough after toggle without flush");

  a_status_keeps_cache: assert property (status_wr && legacy && !legacy_ready_rise
    |=> $stable(cache_q))
    else $error("legacy status write moved cache");

  a_feat_keeps_cache: assert property (drv_feat_wr |=> $stable(cache_q))
    else $error("feature write moved cache");

  a_legacy_cache_write: assert property (cache_wr && legacy |=> cache_q == wdat_q[0])
    else $error("legacy cache write ignored");

endmodule // blk_cfg_space

`default_nettype wire

// [sim/guest_drv_model.sv]
/*
 * guest driver model: classic wishbone master that reaches the block
 * device configuration space on behalf of the bench.
 * assumes one bench clock and a slave that answers each request with ack.
 */
`timescale 1ns/1ps
`default_nettype none

module guest_drv_model (
  input wire logic clk_i, // bus clock
  input wire logic [31:0] dat_i, // read data from slave
  input wire logic ack_i, // slave answer
  output logic [7:0] adr_o, // byte address
  output logic [31:0] dat_o, // write data
  output logic [3:0] sel_o, // byte lanes
  output logic we_o, // write
  output logic cyc_o, // bus cycle
  output logic stb_o // strobe
);
  // cache byte readable: negotiation closed or legacy chosen
  logic open_q = 1'b0;

  // idle bus from time zero
  initial begin
    adr_o = 8'h00;
    dat_o = 32'h0000_0000;
    sel_o = 4'h0;
    we_o = 1'b0;
    cyc_o = 1'b0;
    stb_o = 1'b0;
  end

  // ***********************************
  // one classic cycle, held until ack
  // ***********************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    // a driver never reads the cache byte early; a refused read yields all ones
    if (!w && a == blk_cfg_pkg::OFF_CACHE && !open_q) begin
      q = 32'hFFFF_FFFF;
      return;
    end
    // the driver learns the mode from the byte, not by guessing
    if (w && ((a == blk_cfg_pkg::OFF_STATUS && d[blk_cfg_pkg::ST_FEATURES_ACCEPTED])
      || (a == blk_cfg_pkg::OFF_MODE && d[blk_cfg_pkg::MODE_LEGACY]))) begin
      open_q = 1'b1;
    end
    @(posedge clk_i);
    adr_o <= a;
    dat_o <= d;
    we_o <= w;
    sel_o <= 4'hF;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    // no cycle count assumed; only the bench watchdog ends this wait
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask
endmodule // guest_drv_model

`default_nettype wire

// [sim/tb.sv]
/*
 * self-checking bench of the block device configuration space.
 * assumes the guest driver model and two design copies, one read-only.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] sel;
  logic we, cyc, stb, ack, done, st_en, wb_q, fa, ro_done, ro_en;
  logic [7:0] stat;
  logic [7:0] ro_stat;
  int errors = 0;
  int checks = 0;

  always #20 clk_i = ~clk_i;

  // ***********************************
  // parties
  // ***********************************
  guest_drv_model DRV (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .adr_o(adr), .dat_o(wdat),
    .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
  blk_cfg_space DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_done_o(done), .req_status_o(stat),
    .store_en_o(st_en), .cache_writeback_o(wb_q), .features_accepted_o(fa));
  // read-only copy shares the inputs; only its request gate is judged
  blk_cfg_space #(.OFFER_READ_ONLY(1'b1)) dut_ro (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(), .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_done_o(ro_done),
    .req_status_o(ro_stat), .store_en_o(ro_en), .cache_writeback_o(), .features_accepted_o());

  // ***********************************
  // shared helpers
  // ***********************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    DRV.xfer(1'b1, a, d, q);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    DRV.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    DRV.open_q = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  // every fixed field, offered bits, pads and a hole; writes to read-only places ignored
  task automatic t_fields;
    logic [39:0] fld [16] = '{40'h00_0010_0000, 40'h04_0000_0000, 40'h08_0001_0000, 40'h0C_0000_0080,
      40'h10_3F10_0400, 40'h14_0000_0200, 40'h18_0001_0003, 40'h1C_0000_0080, 40'h24_0000_FFFF,
      40'h28_0000_0001, 40'h2C_0000_0008, 40'h30_0000_FFFF, 40'h34_0000_0001, 40'h38_0000_0001,
      40'h40_0000_6E56, 40'h3C_0000_0000};
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++) begin
      rd(fld[i][39:32], fld[i][31:0]);
    end
  endtask

  // toggle accepted without flush, then the driver switches the cache
  task automatic t_modern;
    chk({31'h0, wb_q}, 32'h1);
    wr(8'h20, 32'h0);
    chk({31'h0, wb_q}, 32'h1);
    wr(8'h44, 32'hFFFF_0800);
    wr(8'h48, 32'h0000_000B);
    chk({30'h0, fa, wb_q}, 32'h2);
    wr(8'h44, 32'h0000_0000);
    rd(8'h44, 32'h0000_0800);
    rd(8'h20, 32'h0);
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h1);
    chk({31'h0, wb_q}, 32'h1);
  endtask

  // legacy: early cache access, status and feature writes, guest order
  task automatic t_legacy;
    do_reset(2);
    wr(8'h4C, 32'h1);
    rd(8'h40, 32'h0000_6E57);
    wr(8'h20, 32'h0);
    rd(8'h20, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h44, 32'h0000_0800);
    rd(8'h20, 32'h1);
    wr(8'h48, 32'h3);
    rd(8'h20, 32'h1);
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h7);
    rd(8'h20, 32'h0);
    wr(8'h4C, 32'h3);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0100);
    rd(8'h04, 32'h0000_1000);
    rd(8'h10, 32'h3F10_0004);
    rd(8'h38, 32'h0000_0001);
  endtask

  // back-to-back write then read on both copies
  task automatic t_req;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= 1'b1;
    @(posedge clk_i);
    req_write_i <= 1'b0;
    #1;
    chk({28'h0, done, st_en, ro_done, ro_en}, 32'hE);
    chk({16'h0, stat, ro_stat}, {16'h0, blk_cfg_pkg::REQ_STATUS_OK, blk_cfg_pkg::IO_ERROR_STATUS});
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
    chk({30'h0, done, ro_done}, 32'h3);
    chk({24'h0, ro_stat}, {24'h0, blk_cfg_pkg::REQ_STATUS_OK});
    @(posedge clk_i);
    #1;
    chk({28'h0, done, st_en, ro_done, ro_en}, 32'h0);
  endtask

  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ***********************************
  // main sequence and watchdog
  // ***********************************
  initial begin
    do_reset(12);
    t_fields();
    t_modern();
    t_req();
    t_legacy();
    finish_test();
  end

  // the whole run needs about 6 us, well under the 100 us watchdog
  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule // tb

`default_nettype wire
